/* rf_frontend_command_handler.sv */
`timescale 1ns/1ps
module rf_frontend_command_handler #(
  parameter int CYCLES_PER_MS = rf_cmd_pkg::CYCLES_PER_MS
) (
  // clock and reset
  input wire logic clk_in,
  input wire logic nrst_in,
  // serial host link
  input wire logic sck_in,
  input wire logic nss_in,
  input wire logic mosi_in,
  output logic miso_out,
  // transceiver status
  input wire logic awaiting_transmit_state_in,
  input wire logic transceive_selected_in,
  input wire logic tx_busy_in,
  // transmit buffer and start
  output logic txbuf_we_out,
  output logic [8:0] txbuf_addr_out,
  output logic [7:0] txbuf_data_out,
  output logic tx_start_out,
  output logic [8:0] tx_len_out,
  output logic [2:0] tx_last_bits_out,
  // receive buffer read port
  output logic [8:0] rxbuf_addr_out,
  input wire logic [7:0] rxbuf_data_in,
  // special mode events
  input wire logic rf_field_in,
  input wire logic card_detected_in,
  input wire logic listen_done_in,
  // special mode status
  output logic mode_standby_out,
  output logic mode_low_power_card_detect_out,
  output logic mode_listen_out,
  output logic card_detect_probe_out,
  output logic listen_standby_out,
  output logic [3:0] listen_tech_out,
  output logic [1:0] listen_submode_out,
  output logic [7:0] wake_mask_out,
  // host signalling
  output logic exception_out,
  output logic irq_out
);
  localparam int TICK_W = $clog2(CYCLES_PER_MS);
  localparam logic [TICK_W-1:0] TICK_LAST = TICK_W'(CYCLES_PER_MS - 1);

  typedef struct packed {
    rf_cmd_pkg::mode_t mode;
    logic nss_prev;
    logic tog_seen;
    logic [2:0] byte_idx;
    logic [7:0] opcode;
    logic [2:0] last_bits;
    logic bits_bad;
    logic [8:0] tx_count;
    logic overflow;
    logic [7:0] p0;
    logic [7:0] p1;
    logic [7:0] p2;
    logic [7:0] p3;
    logic [8:0] rx_ptr;
    logic [7:0] miso_byte;
    logic txbuf_we;
    logic [8:0] txbuf_addr;
    logic [7:0] txbuf_data;
    logic tx_start;
    logic [8:0] tx_len;
    logic [7:0] wake_mask;
    logic [15:0] wake_ms;
    logic [15:0] ms_left;
    logic [TICK_W-1:0] tick_cnt;
    logic probe;
    logic [3:0] tech;
    logic [1:0] submode;
    logic listen_standby;
    logic exception;
    logic irq;
  } state_t;

  state_t st_reg;
  state_t st_next;
  logic nss_s;
  logic tog_s;
  logic field_s;
  logic [7:0] link_byte;
  logic link_toggle;
  logic normal;
  logic byte_evt;
  logic frame_start;
  logic frame_end;

  // the link runs on sck; the toggle, nss and field cross by level sync, both byte words cross without sync
  spi_byte_link u_link (.nrst_in(nrst_in), .sck_in(sck_in), .nss_in(nss_in), .mosi_in(mosi_in),
    .miso_out(miso_out), .tx_byte_in(st_reg.miso_byte), .rx_byte_out(link_byte),
    .rx_toggle_out(link_toggle));
  // nss idles high, so its synchroniser resets high to avoid a false frame start
  level_sync3 #(.RST_VAL(1'b1)) u_nss_sync (.clk_in(clk_in), .nrst_in(nrst_in), .d_in(nss_in), .q_out(nss_s));
  level_sync3 #(.RST_VAL(1'b0)) u_tog_sync (.clk_in(clk_in), .nrst_in(nrst_in), .d_in(link_toggle), .q_out(tog_s));
  level_sync3 #(.RST_VAL(1'b0)) u_field_sync (.clk_in(clk_in), .nrst_in(nrst_in), .d_in(rf_field_in), .q_out(field_s));

  // frame and byte events; link_byte is stable a whole byte after its toggle
  assign normal = st_reg.mode[0];
  assign byte_evt = tog_s ^ st_reg.tog_seen;
  assign frame_start = st_reg.nss_prev & ~nss_s;
  assign frame_end = ~st_reg.nss_prev & nss_s;

  always_comb begin
    logic [15:0] cnt_a;
    logic [15:0] cnt_b;
    logic ms_tick;
    logic bad;
    cnt_a = 16'h0000;
    cnt_b = 16'h0000;
    ms_tick = 1'b0;
    bad = 1'b0;
    st_next = st_reg;
    st_next.nss_prev = nss_s;
    st_next.tog_seen = tog_s;
    st_next.txbuf_we = 1'b0;
    st_next.tx_start = 1'b0;
    st_next.probe = 1'b0;

    // a new frame clears the command context and the last answer flags
    if (frame_start && normal) begin
      st_next.byte_idx = 3'h0;
      st_next.opcode = 8'h00;
      st_next.tx_count = 9'h000;
      st_next.overflow = 1'b0;
      st_next.bits_bad = 1'b0;
      st_next.rx_ptr = 9'h000;
      st_next.miso_byte = 8'h00;
      st_next.exception = 1'b0;
      st_next.irq = 1'b0;
    end

    // bytes during a special mode are dropped: the host must stay silent
    if (byte_evt && normal) begin
      if (st_reg.byte_idx == 3'h0) begin
        st_next.opcode = link_byte;
        if (link_byte == rf_cmd_pkg::CMD_READ_RX) begin
          st_next.miso_byte = rxbuf_data_in;
          st_next.rx_ptr = 9'h001;
        end
      end else begin
        case (st_reg.opcode)
          rf_cmd_pkg::CMD_TRANSMIT: begin
            if (st_reg.byte_idx == 3'h1) begin
              st_next.last_bits = link_byte[2:0];
              st_next.bits_bad = (link_byte > rf_cmd_pkg::LAST_BITS_MAX);
            end else if (st_reg.tx_count < rf_cmd_pkg::TX_BUF_BYTES) begin
              st_next.txbuf_we = 1'b1;
              st_next.txbuf_addr = st_reg.tx_count;
              st_next.txbuf_data = link_byte;
              st_next.tx_count = st_reg.tx_count + 9'h001;
            end else begin
              st_next.overflow = 1'b1;
            end
          end
          rf_cmd_pkg::CMD_READ_RX: begin
            // data runs two bytes behind the pointer, one byte of slack for the crossing
            st_next.miso_byte = rxbuf_data_in;
            if (st_reg.rx_ptr < rf_cmd_pkg::RX_LAST_INDEX) begin
              st_next.rx_ptr = st_reg.rx_ptr + 9'h001;
            end
          end
          rf_cmd_pkg::CMD_SWITCH_MODE: begin
            case (st_reg.byte_idx)
              3'h1: st_next.p0 = link_byte;
              3'h2: st_next.p1 = link_byte;
              3'h3: st_next.p2 = link_byte;
              3'h4: st_next.p3 = link_byte;
              default: st_next.p3 = st_reg.p3;
            endcase
          end
          default: st_next.opcode = st_reg.opcode;
        endcase
      end
      if (st_reg.byte_idx != 3'h7) begin
        st_next.byte_idx = st_reg.byte_idx + 3'h1;
      end
    end

    // the command acts at frame end, when the payload length is known
    cnt_a = {st_next.p3, st_next.p2};
    cnt_b = {st_next.p2, st_next.p1};
    if (frame_end && normal) begin
      case (st_next.opcode)
        rf_cmd_pkg::CMD_TRANSMIT: begin
          bad = st_next.bits_bad | st_next.overflow | tx_busy_in | ~awaiting_transmit_state_in
                | ~transceive_selected_in | (st_next.byte_idx < rf_cmd_pkg::TX_MIN_BYTES);
          if (bad) begin
            st_next.exception = 1'b1;
          end else begin
            st_next.tx_start = 1'b1;
            st_next.tx_len = st_next.tx_count;
          end
        end
        rf_cmd_pkg::CMD_SWITCH_MODE: begin
          case (st_next.p0)
            rf_cmd_pkg::MODE_STANDBY: begin
              bad = (st_next.byte_idx < rf_cmd_pkg::STANDBY_BYTES)
                    | ((st_next.p1 & rf_cmd_pkg::WAKE_RSVD_MASK) != 8'h00)
                    | (st_next.p1[rf_cmd_pkg::WAKE_COUNTER_BIT]
                       & ((cnt_a < rf_cmd_pkg::WAKE_MS_MIN) | (cnt_a > rf_cmd_pkg::WAKE_MS_MAX)));
              if (!bad) begin
                st_next.mode = rf_cmd_pkg::MD_STANDBY;
                st_next.wake_mask = st_next.p1;
                st_next.wake_ms = cnt_a;
                st_next.ms_left = cnt_a;
              end
            end
            rf_cmd_pkg::MODE_CARD_DETECT: begin
              bad = (st_next.byte_idx < rf_cmd_pkg::SHORT_MODE_BYTES)
                    | (cnt_b < rf_cmd_pkg::WAKE_MS_MIN) | (cnt_b > rf_cmd_pkg::WAKE_MS_MAX);
              if (!bad) begin
                st_next.mode = rf_cmd_pkg::MD_CARD_DETECT;
                st_next.wake_ms = cnt_b;
                st_next.ms_left = cnt_b;
              end
            end
            rf_cmd_pkg::MODE_LISTEN: begin
              bad = (st_next.byte_idx < rf_cmd_pkg::SHORT_MODE_BYTES)
                    | ((st_next.p1 & rf_cmd_pkg::TECH_RSVD_MASK) != 8'h00)
                    | (st_next.p2 > rf_cmd_pkg::SUBMODE_MAX);
              if (!bad) begin
                st_next.mode = rf_cmd_pkg::MD_LISTEN;
                st_next.tech = st_next.p1[3:0];
                st_next.submode = st_next.p2[1:0];
              end
            end
            default: bad = 1'b1;
          endcase
          st_next.exception = bad;
          st_next.tick_cnt = '0;
        end
        default: st_next.exception = st_reg.exception;
      endcase
    end

    // millisecond base runs only inside a special mode
    if (!normal) begin
      if (st_reg.tick_cnt == TICK_LAST) begin
        st_next.tick_cnt = '0;
        ms_tick = 1'b1;
      end else begin
        st_next.tick_cnt = st_reg.tick_cnt + TICK_W'(1);
      end
    end

    // each mode ends on its own condition, then normal mode and the interrupt
    case (st_reg.mode)
      rf_cmd_pkg::MD_STANDBY: begin
        if (ms_tick && st_reg.ms_left > 16'h0001) begin
          st_next.ms_left = st_reg.ms_left - 16'h0001;
        end
        if ((st_reg.wake_mask[rf_cmd_pkg::WAKE_FIELD_BIT] && field_s)
            || (st_reg.wake_mask[rf_cmd_pkg::WAKE_COUNTER_BIT] && ms_tick && st_reg.ms_left <= 16'h0001)) begin
          st_next.mode = rf_cmd_pkg::MD_NORMAL;
          st_next.irq = 1'b1;
        end
      end
      rf_cmd_pkg::MD_CARD_DETECT: begin
        if (ms_tick) begin
          if (st_reg.ms_left <= 16'h0001) begin
            st_next.probe = 1'b1;
            st_next.ms_left = st_reg.wake_ms;
          end else begin
            st_next.ms_left = st_reg.ms_left - 16'h0001;
          end
        end
        // no probe may start in the cycle the mode is left
        if (card_detected_in) begin
          st_next.mode = rf_cmd_pkg::MD_NORMAL;
          st_next.probe = 1'b0;
          st_next.irq = 1'b1;
        end
      end
      rf_cmd_pkg::MD_LISTEN: begin
        st_next.listen_standby = (st_reg.submode == rf_cmd_pkg::SUBMODE_STANDBY) & ~field_s;
        if (listen_done_in || (st_reg.submode == rf_cmd_pkg::SUBMODE_END && !field_s)) begin
          st_next.mode = rf_cmd_pkg::MD_NORMAL;
          st_next.listen_standby = 1'b0;
          st_next.irq = 1'b1;
        end
      end
      rf_cmd_pkg::MD_NORMAL: st_next.listen_standby = 1'b0;
      default: st_next.mode = rf_cmd_pkg::MD_NORMAL;
    endcase
  end

  always_ff @(posedge clk_in or negedge nrst_in) begin
    if (!nrst_in) begin
      st_reg <= '0;
      st_reg.mode <= rf_cmd_pkg::MD_NORMAL;
      st_reg.nss_prev <= 1'b1;
    end else begin
      st_reg <= st_next;
    end
  end

  // every output except miso_out is a field of the state register
  assign txbuf_we_out = st_reg.txbuf_we;
  assign txbuf_addr_out = st_reg.txbuf_addr;
  assign txbuf_data_out = st_reg.txbuf_data;
  assign tx_start_out = st_reg.tx_start;
  assign tx_len_out = st_reg.tx_len;
  assign tx_last_bits_out = st_reg.last_bits;
  assign rxbuf_addr_out = st_reg.rx_ptr;
  assign mode_standby_out = st_reg.mode[1];
  assign mode_low_power_card_detect_out = st_reg.mode[2];
  assign mode_listen_out = st_reg.mode[3];
  assign card_detect_probe_out = st_reg.probe;
  assign listen_standby_out = st_reg.listen_standby;
  assign listen_tech_out = st_reg.tech;
  assign listen_submode_out = st_reg.submode;
  assign wake_mask_out = st_reg.wake_mask;
  assign exception_out = st_reg.exception;
  assign irq_out = st_reg.irq;

  default clocking cb @(posedge clk_in); endclocking
  default disable iff (!nrst_in);

  sequence s_mode_exit;
    !normal ##1 normal;
  endsequence
  sequence s_tx_end;
    frame_end && normal && st_next.opcode == rf_cmd_pkg::CMD_TRANSMIT;
  endsequence

  a_tx_start_pulse: assert property (tx_start_out |=> !tx_start_out)
    else $error("transmit start longer than one cycle");
  a_tx_len_bound: assert property (tx_start_out |-> tx_len_out <= rf_cmd_pkg::TX_BUF_BYTES)
    else $error("transmit length above buffer size");
  a_tx_guard_state: assert property (tx_start_out |-> $past(awaiting_transmit_state_in)
      && $past(transceive_selected_in) && !$past(tx_busy_in))
    else $error("transmit started in a forbidden transceiver state");
  a_tx_bits_bad: assert property (s_tx_end and st_next.bits_bad |=> exception_out && !tx_start_out)
    else $error("bad bit count not refused");
  a_tx_ok_start: assert property (s_tx_end and !st_next.bits_bad && !st_next.overflow && !tx_busy_in
      && awaiting_transmit_state_in && transceive_selected_in && st_next.byte_idx >= 3'h2
      |=> tx_start_out && tx_last_bits_out == $past(st_next.last_bits))
    else $error("valid transmit not started");
  a_mode_from_normal: assert property (!normal && $past(normal) |-> $past(frame_end)
      && $past(st_next.opcode) == rf_cmd_pkg::CMD_SWITCH_MODE)
    else $error("special mode entered without a switch command");
  a_irq_on_exit: assert property (s_mode_exit |-> irq_out ##1 irq_out)
    else $error("mode termination without interrupt");
  a_wake_range: assert property ($rose(mode_standby_out) && wake_mask_out[0] |->
      st_reg.wake_ms >= rf_cmd_pkg::WAKE_MS_MIN && st_reg.wake_ms <= rf_cmd_pkg::WAKE_MS_MAX)
    else $error("standby counter out of range");
  a_card_probe_mode: assert property (card_detect_probe_out |-> mode_low_power_card_detect_out
      ##1 !card_detect_probe_out)
    else $error("card detection probe outside its mode");
  a_rx_sequence: assert property (byte_evt && normal && st_reg.byte_idx != 3'h0
      && st_reg.opcode == rf_cmd_pkg::CMD_READ_RX && st_reg.rx_ptr < rf_cmd_pkg::RX_LAST_INDEX
      |=> rxbuf_addr_out == $past(rxbuf_addr_out) + 9'h001)
    else $error("receive pointer did not advance");
endmodule

/* rf_cmd_pkg.sv */
package rf_cmd_pkg;
  // command codes
  localparam logic [7:0] CMD_TRANSMIT = 8'h09;
  localparam logic [7:0] CMD_READ_RX = 8'h0A;
  localparam logic [7:0] CMD_SWITCH_MODE = 8'h0B;
  // buffer sizes: 260 transmit bytes, 508 receive bytes
  localparam logic [8:0] TX_BUF_BYTES = 9'h104;
  localparam logic [8:0] RX_LAST_INDEX = 9'h1FB;
  localparam logic [7:0] LAST_BITS_MAX = 8'h07;
  // mode byte values
  localparam logic [7:0] MODE_STANDBY = 8'h00;
  localparam logic [7:0] MODE_CARD_DETECT = 8'h01;
  localparam logic [7:0] MODE_LISTEN = 8'h02;
  // parameter validity
  localparam logic [15:0] WAKE_MS_MIN = 16'h0001;
  localparam logic [15:0] WAKE_MS_MAX = 16'h0A82;
  localparam logic [7:0] WAKE_RSVD_MASK = 8'hFC;
  localparam int WAKE_FIELD_BIT = 1;
  localparam int WAKE_COUNTER_BIT = 0;
  localparam logic [7:0] TECH_RSVD_MASK = 8'hF0;
  localparam logic [7:0] SUBMODE_MAX = 8'h02;
  localparam logic [1:0] SUBMODE_END = 2'h0;
  localparam logic [1:0] SUBMODE_STANDBY = 2'h1;
  // byte counts a complete command needs (code, mode or bit count, parameters)
  localparam logic [2:0] STANDBY_BYTES = 3'h5;
  localparam logic [2:0] SHORT_MODE_BYTES = 3'h4;
  localparam logic [2:0] TX_MIN_BYTES = 3'h2;
  // timing: one millisecond in ns against a 20 ns clock
  localparam int MS_NS = 1000000;
  localparam int CLK_PERIOD_NS = 20;
  localparam int CYCLES_PER_MS = MS_NS / CLK_PERIOD_NS;
  // operating modes, one-hot
  typedef enum logic [3:0] {
    MD_NORMAL = 4'b0001,
    MD_STANDBY = 4'b0010,
    MD_CARD_DETECT = 4'b0100,
    MD_LISTEN = 4'b1000
  } mode_t;
endpackage

/* level_sync3.sv */
`timescale 1ns/1ps
module level_sync3 #(
  parameter logic RST_VAL = 1'b0
) (
  // clock and reset
  input wire logic clk_in,
  input wire logic nrst_in,
  // level in and settled level out
  input wire logic d_in,
  output logic q_out
);
  typedef struct packed {
    logic s1;
    logic s2;
    logic s3;
    logic q;
  } sync_t;

  sync_t sy_reg;
  sync_t sy_next;

  // the output moves only once the second and third stages agree
  always_comb begin
    sy_next = sy_reg;
    sy_next.s1 = d_in;
    sy_next.s2 = sy_reg.s1;
    sy_next.s3 = sy_reg.s2;
    if (sy_reg.s2 == sy_reg.s3) begin
      sy_next.q = sy_reg.s3;
    end
  end

  always_ff @(posedge clk_in or negedge nrst_in) begin
    if (!nrst_in) begin
      sy_reg <= {4{RST_VAL}};
    end else begin
      sy_reg <= sy_next;
    end
  end

  assign q_out = sy_reg.q;
endmodule

/* spi_byte_link.sv */
`timescale 1ns/1ps
module spi_byte_link (
  // reset
  input wire logic nrst_in,
  // serial pins, mode 0, msb first
  input wire logic sck_in,
  input wire logic nss_in,
  input wire logic mosi_in,
  output logic miso_out,
  // byte words toward the system clock
  input wire logic [7:0] tx_byte_in,
  output logic [7:0] rx_byte_out,
  output logic rx_toggle_out
);
  typedef struct packed {
    logic [2:0] bit_cnt;
    logic [6:0] shift;
  } frame_t;
  typedef struct packed {
    logic [7:0] rx_byte;
    logic toggle;
  } word_t;

  frame_t fr_reg;
  frame_t fr_next;
  word_t wd_reg;
  word_t wd_next;
  logic [7:0] tx_shift_reg;
  logic [7:0] tx_shift_next;
  logic link_clr;

  // sck stops between frames, so the bit counter is cleared by nss itself
  assign link_clr = nss_in | ~nrst_in;

  always_comb begin
    fr_next = fr_reg;
    wd_next = wd_reg;
    fr_next.bit_cnt = fr_reg.bit_cnt + 3'h1;
    fr_next.shift = {fr_reg.shift[5:0], mosi_in};
    if (fr_reg.bit_cnt == 3'h7) begin
      wd_next.rx_byte = {fr_reg.shift, mosi_in};
      wd_next.toggle = ~wd_reg.toggle;
    end
    // the next byte is loaded after the last edge of the previous one
    if (fr_reg.bit_cnt == 3'h0) begin
      tx_shift_next = tx_byte_in;
    end else begin
      tx_shift_next = {tx_shift_reg[6:0], 1'b0};
    end
  end

  always_ff @(posedge sck_in or posedge link_clr) begin
    if (link_clr) begin
      fr_reg <= '0;
    end else begin
      fr_reg <= fr_next;
    end
  end

  // the toggle survives nss so the far side never sees a false byte
  always_ff @(posedge sck_in or negedge nrst_in) begin
    if (!nrst_in) begin
      wd_reg <= '0;
    end else begin
      wd_reg <= wd_next;
    end
  end

  always_ff @(negedge sck_in or posedge link_clr) begin
    if (link_clr) begin
      tx_shift_reg <= 8'h00;
    end else begin
      tx_shift_reg <= tx_shift_next;
    end
  end

  assign miso_out = tx_shift_reg[7];
  assign rx_byte_out = wd_reg.rx_byte;
  assign rx_toggle_out = wd_reg.toggle;
endmodule

/* spi_host_model.sv */
`timescale 1ns/1ps
module spi_host_model (
  // serial pins toward the device
  output logic sck_out,
  output logic nss_out,
  output logic mosi_out,
  input wire logic miso_in
);
  logic [7:0] tx_q[$];
  logic [7:0] rx_q[$];
  initial begin
    sck_out = 1'b0;
    nss_out = 1'b1;
    mosi_out = 1'b1;
  end
  // one frame, mode 0, msb first; the clock stands low outside frames
  task automatic frame();
    logic [7:0] b;
    logic [7:0] r;
    rx_q = {};
    nss_out = 1'b0;
    #40;
    while (tx_q.size() > 0) begin
      b = tx_q.pop_front();
      for (int i = 7; i >= 0; i--) begin
        mosi_out = b[i];
        #15 sck_out = 1'b1;
        r[i] = miso_in;
        #15 sck_out = 1'b0;
      end
      rx_q.push_back(r);
    end
    #40 nss_out = 1'b1;
    // released line must not keep showing the last bit
    mosi_out = ~mosi_out;
    #200;
  endtask
endmodule

/* test_rf_frontend_command_handler.sv */
`timescale 1ns/1ps
module test_rf_frontend_command_handler;
  logic clk_in = 1'b0;
  logic nrst_in = 1'b0;
  logic sck, nss, mosi, miso, we, start, st_mode, probe, exc, irq;
  logic cd_mode, ls_mode, ls_stby;
  logic wait_tx = 1'b1;
  logic sel = 1'b1;
  logic busy = 1'b0;
  logic field = 1'b0;
  logic card = 1'b0;
  logic ldone = 1'b0;
  logic [8:0] waddr, len, raddr;
  logic [7:0] wdata, wm;
  logic [3:0] tech;
  logic [2:0] lbits;
  logic [2:0] bad [3] = '{3'b111, 3'b001, 3'b010};
  logic [23:0] exp_q[$];
  logic exc_d = 1'b0;
  logic irq_d = 1'b0;
  logic [31:0] seed = 32'h62;
  int err_count = 0;
  int total_checks = 0;
  int cycles = 0;
  int probes = 0;
  int c;
  always #10 clk_in = ~clk_in;
  // receive buffer pattern follows the read index
  wire logic [7:0] rxdata = raddr[7:0] ^ 8'h5A;
  spi_host_model u_spi_host_model (.sck_out(sck), .nss_out(nss), .mosi_out(mosi), .miso_in(miso));
  rf_frontend_command_handler #(.CYCLES_PER_MS(10)) u_rf_frontend_command_handler (
    .clk_in(clk_in), .nrst_in(nrst_in), .sck_in(sck), .nss_in(nss), .mosi_in(mosi), .miso_out(miso),
    .awaiting_transmit_state_in(wait_tx), .transceive_selected_in(sel), .tx_busy_in(busy),
    .txbuf_we_out(we), .txbuf_addr_out(waddr), .txbuf_data_out(wdata), .tx_start_out(start),
    .tx_len_out(len), .tx_last_bits_out(lbits), .rxbuf_addr_out(raddr), .rxbuf_data_in(rxdata),
    .rf_field_in(field), .card_detected_in(card), .listen_done_in(ldone), .mode_standby_out(st_mode),
    .mode_low_power_card_detect_out(cd_mode), .mode_listen_out(ls_mode), .card_detect_probe_out(probe),
    .listen_standby_out(ls_stby),
    .listen_tech_out(tech), .listen_submode_out(), .wake_mask_out(wm), .exception_out(exc), .irq_out(irq));
  function automatic logic [31:0] rnd();
    seed = seed ^ (seed << 13);
    seed = seed ^ (seed >> 17);
    seed = seed ^ (seed << 5);
    return seed;
  endfunction
  task automatic check(input logic [23:0] seen, input logic [23:0] want);
    total_checks++;
    if (seen !== want) begin
      err_count++;
      $display("CHECK FAILED t=%0t seen=%h exp=%h", $time, seen, want);
    end
  endtask
  task automatic take(input logic [23:0] seen);
    if (exp_q.size() == 0) check(seen, 24'hFFFFFF);
    else check(seen, exp_q.pop_front());
  endtask
  task automatic print_verdict();
    if (err_count == 0 && total_checks > 0) $display("TB: PASS");
    else $display("TB: FAIL");
    $finish;
  endtask
  // watcher: every buffer write, start, refusal and mode end is an event
  always @(posedge clk_in) begin
    exc_d <= exc;
    irq_d <= irq;
    if (probe) probes <= probes + 1;
    if (we) take({4'h1, 3'h0, waddr, wdata});
    if (start) take({4'h2, 5'h0, lbits, 3'h0, len});
    if (exc && !exc_d) take(24'hE00000);
    if (irq && !irq_d) take(24'hF00000);
    cycles++;
    if (cycles == 30000) begin
      err_count++;
      print_verdict();
    end
  end
  task automatic tx(input logic [7:0] bits, input int n, input logic ok);
    logic [7:0] d;
    u_spi_host_model.tx_q = {8'h09, bits};
    for (int i = 0; i < n; i++) begin
      d = 8'(rnd());
      u_spi_host_model.tx_q.push_back(d);
      exp_q.push_back({4'h1, 3'h0, 9'(i), d});
    end
    exp_q.push_back(ok ? {4'h2, 5'h0, bits[2:0], 3'h0, 9'(n)} : 24'hE00000);
    u_spi_host_model.frame();
  endtask
  // counters go low byte first
  task automatic mode(input logic [7:0] m, p0, p1, p2, input logic [23:0] ev);
    u_spi_host_model.tx_q = {8'h0B, m, p0, p1, p2};
    if (ev != 24'h0) exp_q.push_back(ev);
    u_spi_host_model.frame();
  endtask
  task automatic wait_irq(input int lim);
    c = 0;
    while (irq !== 1'b1 && c < lim) begin
      @(posedge clk_in);
      c++;
    end
    #1 check({23'h0, irq}, 24'h1);
  endtask
  initial begin
    repeat (8) @(posedge clk_in);
    @(negedge clk_in) nrst_in = 1'b1;
    repeat (6) @(negedge clk_in);
    for (int k = 0; k < 8; k++) tx(8'(k), 1 + int'(rnd() % 32'h5), 1'b1);
    tx(8'h07, 260, 1'b1);
    tx(8'h00, 0, 1'b1);
    tx(8'h08, 0, 1'b0);
    for (int k = 0; k < 3; k++) begin
      @(negedge clk_in) {busy, wait_tx, sel} = bad[k];
      tx(8'h00, 0, 1'b0);
    end
    @(negedge clk_in) {busy, wait_tx, sel} = 3'b011;
    u_spi_host_model.tx_q = {8'h0A, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00};
    u_spi_host_model.frame();
    for (int k = 2; k < 7; k++) check({16'h0, u_spi_host_model.rx_q[k]}, {16'h0, 8'(k - 2) ^ 8'h5A});
    mode(8'h03, 8'h01, 8'h01, 8'h00, 24'hE00000);
    mode(8'h00, 8'h05, 8'h03, 8'h00, 24'hE00000);
    mode(8'h00, 8'h01, 8'h83, 8'h0A, 24'hE00000);
    mode(8'h00, 8'h01, 8'h00, 8'h00, 24'hE00000);
    mode(8'h00, 8'h01, 8'h03, 8'h00, 24'hF00000);
    check({23'h0, st_mode}, 24'h1);
    check({16'h0, wm}, 24'h1);
    wait_irq(40);
    check({23'h0, (c >= 10 && c <= 32)}, 24'h1);
    // field wake with the counter ignored, then at the counter ceiling
    for (int k = 0; k < 2; k++) begin
      mode(8'h00, 8'h02 | 8'(k), k ? 8'h82 : 8'h00, k ? 8'h0A : 8'h00, 24'hF00000);
      u_spi_host_model.tx_q = {8'h0B, 8'h05};
      u_spi_host_model.frame();
      check({23'h0, st_mode}, 24'h1);
      @(negedge clk_in) field = 1'b1;
      wait_irq(12);
      @(negedge clk_in) field = 1'b0;
    end
    mode(8'h01, 8'h02, 8'h00, 8'h00, 24'hF00000);
    probes = 0;
    repeat (70) @(posedge clk_in);
    check({23'h0, (probes >= 3 && probes <= 4)}, 24'h1);
    check({23'h0, cd_mode}, 24'h1);
    @(negedge clk_in) card = 1'b1;
    wait_irq(6);
    @(negedge clk_in) card = 1'b0;
    check({23'h0, cd_mode}, 24'h0);
    mode(8'h02, 8'h1F, 8'h00, 8'h00, 24'hE00000);
    mode(8'h02, 8'h0F, 8'h03, 8'h00, 24'hE00000);
    mode(8'h02, 8'h0F, 8'h00, 8'h00, 24'hF00000);
    wait_irq(10);
    mode(8'h02, 8'h05, 8'h02, 8'h00, 24'hF00000);
    check({20'h0, tech}, 24'h5);
    check({23'h0, ls_mode}, 24'h1);
    @(negedge clk_in) ldone = 1'b1;
    wait_irq(10);
    @(negedge clk_in) ldone = 1'b0;
    // sub-mode 1 parks in standby while no field is present
    mode(8'h02, 8'h0F, 8'h01, 8'h00, 24'hF00000);
    check({22'h0, ls_mode, ls_stby}, 24'h3);
    @(negedge clk_in) field = 1'b1;
    repeat (8) @(negedge clk_in);
    check({22'h0, ls_mode, ls_stby}, 24'h2);
    @(negedge clk_in) field = 1'b0;
    ldone = 1'b1;
    wait_irq(10);
    @(negedge clk_in) ldone = 1'b0;
    // mask 0 never wakes: only a reset leaves
    mode(8'h00, 8'h00, 8'h01, 8'h00, 24'h0);
    check({23'h0, st_mode}, 24'h1);
    @(negedge clk_in) nrst_in = 1'b0;
    @(negedge clk_in) check({23'h0, st_mode}, 24'h0);
    nrst_in = 1'b1;
    repeat (6) @(negedge clk_in);
    tx(8'h03, 2, 1'b1);
    repeat (10) @(posedge clk_in);
    check(24'(exp_q.size()), 24'h0);
    print_verdict();
  end
endmodule
